/* File: logic/omlp_regs.vh */
// Constants for the OR / move / pointer-load / file-move executor.
`ifndef OMLP_REGS_VH
`define OMLP_REGS_VH
// Opcode patterns, upper bits of the instruction word.
`define OMLP_OP_IOR 6'h04
`define OMLP_OP_MOVE_FILE_VALUE 6'h14
`define OMLP_OP_LOAD_POINTER_LITERAL 8'hee
`define OMLP_LOAD_POINTER_LITERAL_SUB 2'h0
`define OMLP_OP_FF1 4'hc
`define OMLP_OP_FF2 4'hf
// Operand field positions.
`define OMLP_BIT_D 9
`define OMLP_BIT_A 8
// Indexed literal offset limit.
`define OMLP_IDX_MAX 8'h5f
// Access bank split: offsets below 8'h60 in bank 0, the rest in bank 15.
`define OMLP_ACC_SPLIT 8'h60
`define OMLP_ACC_HI_BANK 4'hf
// Special data-space addresses.
`define OMLP_ADDR_WREG 12'hfe8
`define OMLP_ADDR_PCL 12'hff9
`define OMLP_ADDR_TOP_OF_STACK_LOW 12'hffd
`define OMLP_ADDR_TOP_OF_STACK_HIGH 12'hffe
`define OMLP_ADDR_TOP_OF_STACK_UPPER 12'hfff
// Reset values.
`define OMLP_RST_BYTE 8'h00
`define OMLP_RST_PTR 12'h000
// Phase codes, one-hot.
`define OMLP_Q1 4'h1
`define OMLP_Q2 4'h2
`define OMLP_Q3 4'h4
`define OMLP_Q4 4'h8
`endif

/* File: logic/omlp_phase.v */
// Four-phase generator for the instruction cycle.
`timescale 1ns/100ps
`default_nettype none
`include "omlp_regs.vh"
module omlp_phase (
  // Clock and reset.
  input wire core_clk_i,
  input wire rst_n_i,
  // Phase outputs.
  output reg [3:0] phase_o
);
  // Rotate one-hot phase every clock; each core clock is one phase.
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_o <= `OMLP_Q1;
    end else begin
      phase_o <= {phase_o[2:0], phase_o[3]};
    end
  end
endmodule // omlp_phase
`default_nettype wire

/* File: logic/omlp_exec.v */
// Decode and execute for OR-with-file, move, pointer load, file move.
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "omlp_regs.vh"
module omlp_exec (
  // Clock and reset.
  input wire core_clk_i,
  input wire rst_n_i,
  // Instruction stream and mode.
  input wire [15:0] instr_i,
  input wire instr_valid_i,
  input wire ext_set_en_i,
  input wire [3:0] bank_select_i,
  // Data memory port.
  input wire [7:0] mem_rdata_i,
  output reg [11:0] mem_addr_o,
  output reg mem_rd_o,
  output reg mem_wr_o,
  output reg [7:0] mem_wdata_o,
  // Core state.
  output reg [7:0] accum_o,
  output reg neg_flag_o,
  output reg zero_flag_o,
  output reg [11:0] ptr0_o,
  output reg [11:0] ptr1_o,
  output reg [11:0] ptr2_o,
  output reg [3:0] phase_o,
  output reg bad_dest_o
);
  // Instruction-cycle states, one-hot.
  // S_IDLE waits for a valid first word at the next Q1 edge.
  // S_ONE carries every first word through its Q2 to Q4 work.
  // S_LFSR2 and S_FF2 take the second word of a two-word instruction
  // at the next Q1 (S_FF2 drops to idle on a valid word without the prefix); that word is an operand and
  // must never be decoded as an instruction of its own.
  // The pointer-load second word is taken whether or not the valid
  // input is high; the file-move second word is checked for its prefix
  // so that a caller who abandons the move with a fresh valid word is
  // not silently given a write to a random address.
  localparam S_IDLE = 4'h1;
  localparam S_ONE = 4'h2;
  localparam S_LFSR2 = 4'h4;
  localparam S_FF2 = 4'h8;

  reg rst_meta_reg;
  reg rst_sync_reg;
  wire rst_n;
  wire [3:0] phase;
  reg [3:0] state_reg;
  reg [15:0] ir_reg;
  reg [11:0] src_reg;
  reg [7:0] data_reg;
  reg [1:0] psel_reg;
  reg [11:0] fea;
  reg [7:0] res;
  wire is_ior;
  wire is_move_file_value;
  wire is_load_pointer_literal;
  wire is_ff1;
  wire is_ff2;

  // Reset release through two flip-flops.
  // The pin reset may rise at any time relative to the clock, so the
  // release is retimed here before any state machine sees it.
  // Assertion stays asynchronous: the block clears even with no clock.
  // Everything below, the phase generator included, uses the retimed
  // copy, so all registers leave reset on the same edge.
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  omlp_phase u_phase (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .phase_o(phase)
  );

  // Effective address of a single-word file operand.
  // With the bank bit set, the bank select value supplies the upper
  // nibble and the 8-bit field picks a byte inside that bank.
  // With the bank bit clear, the access bank is used: its low part maps
  // to the bottom of bank 0 and its high part to the top of bank 15,
  // which is where the special function registers live.
  // The indexed mode, when enabled, replaces the low part of the access
  // bank with an offset from the third pointer register.
  // The addition wraps at the 12-bit data space; a pointer near the top
  // of memory therefore reaches the bottom, which software must avoid.
  // This is a function because both the read in Q2 and the write in Q4
  // need the same address and must never disagree.
  function [11:0] file_addr;
    input [15:0] w;
    input [3:0] bank_select_reg;
    input ext;
    input [11:0] ptr2;
    begin
      if (w[`OMLP_BIT_A]) begin
        file_addr = {bank_select_reg, w[7:0]};
      end else if (ext && (w[7:0] <= `OMLP_IDX_MAX)) begin
        file_addr = ptr2 + {4'h0, w[7:0]};
      end else if (w[7:0] < `OMLP_ACC_SPLIT) begin
        file_addr = {4'h0, w[7:0]};
      end else begin
        file_addr = {`OMLP_ACC_HI_BANK, w[7:0]};
      end
    end
  endfunction

  // Write into the accumulator also when addressed as data space.
  function is_wreg;
    input [11:0] a;
    begin
      is_wreg = (a == `OMLP_ADDR_WREG);
    end
  endfunction

  // Opcode decode from the latched word.
  // All decodes but one look at the instruction register, so they stay
  // stable through Q2 to Q4 while the input bus is free to change.
  // The file-move second-word check looks at the live input instead,
  // since it must decide at the very Q1 edge whether to take the word.
  // Opcodes not listed here fall through every branch and do nothing.
  assign is_ior = (ir_reg[15:10] == `OMLP_OP_IOR);
  assign is_move_file_value = (ir_reg[15:10] == `OMLP_OP_MOVE_FILE_VALUE);
  assign is_load_pointer_literal = (ir_reg[15:8] == `OMLP_OP_LOAD_POINTER_LITERAL) &&
                   (ir_reg[7:6] == `OMLP_LOAD_POINTER_LITERAL_SUB);
  assign is_ff1 = (ir_reg[15:12] == `OMLP_OP_FF1);
  assign is_ff2 = (instr_i[15:12] == `OMLP_OP_FF2);

  // Result of the arithmetic in Q3.
  always @* begin
    fea = file_addr(ir_reg, bank_select_i, ext_set_en_i, ptr2_o);
    if (is_ior) begin
      res = accum_o | data_reg;
    end else begin
      res = data_reg;
    end
  end

  // Sequencer: words are taken in Q1, work spread across Q2..Q4.
  // Each core clock is one phase, so an instruction cycle is four
  // clocks and one instruction is accepted per cycle at most.
  // Q1 latches the word, Q2 issues the operand read, Q3 captures the
  // read data one clock after the strobe, and Q4 writes the result.
  // All outputs are registered, so what is decided at a phase edge is
  // seen on the pins during the clock that follows it.
  // Strobes are cleared every clock, so each is a single-clock pulse.
  // The accumulator lives here as well as in the data space; an access
  // to its data-space address is steered to the register and never to
  // the memory port, so a file operand that names it reads the true
  // value and a result written to it lands in the register.
  // Flags change only for the OR and the single move; the pointer load
  // and the file move leave them alone.
  // A file move to the program counter or a stack-top byte has no
  // defined effect; the write is dropped and a one-clock pulse reports
  // it, so system logic can trap the attempt.
  // Limitation: the bank select and the mode input are sampled live in
  // Q2, Q3 and Q4; they must not change inside an instruction cycle.
  // Trade-off: the read data is taken straight from the memory port in
  // Q3 with no buffer, which keeps the path short but requires the
  // memory to answer within one clock of the strobe.
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      ir_reg <= 16'h0000;
      src_reg <= `OMLP_RST_PTR;
      data_reg <= `OMLP_RST_BYTE;
      psel_reg <= 2'h0;
      mem_addr_o <= `OMLP_RST_PTR;
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      mem_wdata_o <= `OMLP_RST_BYTE;
      accum_o <= `OMLP_RST_BYTE;
      neg_flag_o <= 1'b0;
      zero_flag_o <= 1'b0;
      ptr0_o <= `OMLP_RST_PTR;
      ptr1_o <= `OMLP_RST_PTR;
      ptr2_o <= `OMLP_RST_PTR;
      phase_o <= `OMLP_Q1;
      bad_dest_o <= 1'b0;
    end else begin
      phase_o <= phase;
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      bad_dest_o <= 1'b0;
      case (phase)
        // Q1 decode: latch the word for this cycle.
        `OMLP_Q1: begin
          if (state_reg == S_LFSR2 || state_reg == S_FF2) begin
            ir_reg <= instr_i;
            state_reg <= (instr_valid_i && state_reg == S_FF2 && !is_ff2)
                         ? S_IDLE : state_reg;
          end else if (instr_valid_i) begin
            ir_reg <= instr_i;
            state_reg <= S_ONE;
          end else begin
            state_reg <= S_IDLE;
          end
        end
        // Q2 read operand.
        `OMLP_Q2: begin
          if (state_reg == S_ONE && (is_ior || is_move_file_value)) begin
            mem_addr_o <= fea;
            mem_rd_o <= !is_wreg(fea);
          end else if (state_reg == S_ONE && is_ff1) begin
            mem_addr_o <= ir_reg[11:0];
            mem_rd_o <= !is_wreg(ir_reg[11:0]);
            src_reg <= ir_reg[11:0];
          end else if (state_reg == S_ONE && is_load_pointer_literal) begin
            psel_reg <= ir_reg[5:4];
          end
        end
        // Q3 process: capture read data.
        `OMLP_Q3: begin
          if (state_reg == S_ONE && (is_ior || is_move_file_value || is_ff1)) begin
            // The accumulator as operand is read from its own register.
            data_reg <= ((is_ff1 && is_wreg(src_reg)) ||
                         (!is_ff1 && is_wreg(fea)))
                        ? accum_o : mem_rdata_i;
          end
        end
        // Q4 write destination.
        `OMLP_Q4: begin
          if (state_reg == S_ONE && (is_ior || is_move_file_value)) begin
            neg_flag_o <= res[7];
            zero_flag_o <= (res == 8'h00);
            if (ir_reg[`OMLP_BIT_D]) begin
              mem_addr_o <= fea;
              mem_wdata_o <= res;
              if (is_wreg(fea)) begin
                accum_o <= res;
              end else begin
                mem_wr_o <= 1'b1;
              end
            end else begin
              accum_o <= res;
            end
            state_reg <= S_IDLE;
          end else if (state_reg == S_ONE && is_load_pointer_literal) begin
            // High part goes now; low byte arrives with word two.
            case (psel_reg)
              2'h0: ptr0_o[11:8] <= ir_reg[3:0];
              2'h1: ptr1_o[11:8] <= ir_reg[3:0];
              2'h2: ptr2_o[11:8] <= ir_reg[3:0];
              default: ptr2_o <= ptr2_o;
            endcase
            state_reg <= S_LFSR2;
          end else if (state_reg == S_ONE && is_ff1) begin
            state_reg <= S_FF2;
          end else if (state_reg == S_LFSR2) begin
            case (psel_reg)
              2'h0: ptr0_o[7:0] <= ir_reg[7:0];
              2'h1: ptr1_o[7:0] <= ir_reg[7:0];
              2'h2: ptr2_o[7:0] <= ir_reg[7:0];
              default: ptr2_o <= ptr2_o;
            endcase
            state_reg <= S_IDLE;
          end else if (state_reg == S_FF2) begin
            // Second word: no dummy read, write in the last phase.
            mem_addr_o <= ir_reg[11:0];
            mem_wdata_o <= data_reg;
            if (is_wreg(ir_reg[11:0])) begin
              accum_o <= data_reg;
            end else if (ir_reg[11:0] == `OMLP_ADDR_PCL ||
                         ir_reg[11:0] >= `OMLP_ADDR_TOP_OF_STACK_LOW) begin
              bad_dest_o <= 1'b1;
            end else begin
              mem_wr_o <= 1'b1;
            end
            state_reg <= S_IDLE;
          end else begin
            state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule // omlp_exec
`default_nettype wire

/* File: tb/omlp_exec_asserts.sv */
// Port checker for the OR / move / pointer-load executor.
`timescale 1ns/100ps
`default_nettype none
module omlp_exec_chk (
  // Clock, reset and watched outputs.
  input wire logic core_clk_i, rst_n_i, mem_rd_o, mem_wr_o,
  input wire logic neg_flag_o, zero_flag_o, bad_dest_o,
  input wire logic [11:0] mem_addr_o, ptr0_o, ptr1_o, ptr2_o,
  input wire logic [7:0] accum_o,
  input wire logic [3:0] phase_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Starting from Q2 skips the cycles the reset synchroniser holds Q1.
  a_phase_order: assert property (phase_o == 4'h2 |=> phase_o == 4'h4
    ##1 phase_o == 4'h8 ##1 phase_o == 4'h1) else $error("phase order");
  a_read_in_q2: assert property (mem_rd_o |-> phase_o == 4'h2
    ##1 !mem_rd_o) else $error("read strobe timing");
  a_write_in_q4: assert property (mem_wr_o |-> phase_o == 4'h8
    ##1 !mem_wr_o) else $error("write strobe timing");
  a_write_legal: assert property (mem_wr_o |-> !(mem_addr_o inside
    {12'hff9, 12'hffd, 12'hffe, 12'hfff})) else $error("write to PC/stack");
  a_bad_drops: assert property (bad_dest_o |-> !mem_wr_o ##1
    !bad_dest_o) else $error("bad destination pulse");
  a_accum_q4: assert property ($changed(accum_o) |->
    phase_o == 4'h8) else $error("accumulator changed off Q4");
  a_flags_q4: assert property ($changed(neg_flag_o) ||
    $changed(zero_flag_o) |-> phase_o == 4'h8) else $error("flags off Q4");
  a_ptr_keeps_flags: assert property ($changed(ptr0_o) ||
    $changed(ptr1_o) || $changed(ptr2_o) |-> phase_o == 4'h8 &&
    $stable(neg_flag_o) && $stable(zero_flag_o)) else $error("pointer load");
endmodule // omlp_exec_chk
bind omlp_exec omlp_exec_chk u_chk (.*);
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the OR / move / pointer-load executor.
`timescale 1ns/100ps
`default_nettype none
`include "omlp_regs.vh"
module tb;
  logic core_clk_i, rst_n_i, instr_valid_i, ext_set_en_i, e, d, ab;
  logic mem_rd_o, mem_wr_o, neg_flag_o, zero_flag_o, bad_dest_o;
  logic [15:0] instr_i;
  logic [3:0] bank_select_i, phase_o, b;
  logic [7:0] mem_rdata_i, accum_o, mem_wdata_o, acc, f, r, res, rv;
  logic [11:0] mem_addr_o, ptr0_o, ptr1_o, ptr2_o, a, s, pv[3];
  logic [9:0] st;
  logic [20:0] expq[$];
  int mismatches, compares, bads, nbad;
  omlp_exec DUT (.*);
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Present a word so that the next Q1 edge takes it, then drop valid.
  task automatic issue(input logic [15:0] w, input logic v);
    do @(negedge core_clk_i); while (phase_o !== 4'h4);
    @(posedge core_clk_i);
    instr_i <= w;
    instr_valid_i <= v;
    repeat (2) @(posedge core_clk_i);
    instr_valid_i <= 1'b0;
  endtask
  task automatic fin;
    repeat (6) @(negedge core_clk_i);
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Each strobe takes the oldest expected access off the queue.
  always @(posedge core_clk_i) begin
    if (bad_dest_o === 1'b1) bads++;
    if (mem_rd_o === 1'b1 || mem_wr_o === 1'b1)
      chk({mem_wr_o, mem_addr_o, mem_wr_o ? mem_wdata_o : 8'h00},
          expq.size() ? expq.pop_front() : 21'h1fffff);
  end
  initial begin
    #20000;
    mismatches++;
    final_report;
  end
  initial begin
    {rst_n_i, instr_valid_i, ext_set_en_i, instr_i} = '0;
    {bank_select_i, mem_rdata_i, acc} = '0;
    void'($urandom(68));
    repeat (8) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      pv[i] = $urandom;
      issue({8'hee, 2'h0, i[1:0], pv[i][11:8]}, 1'b1);
      issue({8'hf0, pv[i][7:0]}, 1'b0);
      chk(i == 0 ? ptr0_o : i == 1 ? ptr1_o : ptr2_o,
          {pv[i][11:8], 8'h00});
    end
    fin;
    chk({ptr0_o, ptr1_o, ptr2_o, neg_flag_o, zero_flag_o},
        {pv[0], pv[1], pv[2], 2'b00});
    $display("pointer test done");
    for (int i = 0; i < 24; i++) begin
      @(posedge core_clk_i);
      {d, ab, e, b} = $urandom;
      f = i[1] ? 8'h5f + i[0] : 8'($urandom);
      r = (i % 5) ? 8'($urandom) : 8'h00;
      ext_set_en_i <= e;
      bank_select_i <= b;
      mem_rdata_i <= r;
      a = ab ? {b, f} : (e && f <= `OMLP_IDX_MAX) ? pv[2] + f :
          {f >= `OMLP_ACC_SPLIT ? `OMLP_ACC_HI_BANK : 4'h0, f};
      rv = (a == `OMLP_ADDR_WREG) ? acc : r;
      res = i[2] ? acc | rv : rv;
      if (a != `OMLP_ADDR_WREG) expq.push_back({1'b0, a, 8'h00});
      if (d && a != `OMLP_ADDR_WREG) expq.push_back({1'b1, a, res});
      else acc = res;
      issue({i[2] ? `OMLP_OP_IOR : `OMLP_OP_MOVE_FILE_VALUE, d, ab, f}, 1'b1);
      fin;
      st = {acc, res[7], res == 8'h00};
      chk({accum_o, neg_flag_o, zero_flag_o}, st);
    end
    $display("or and move test done");
    for (int i = 0; i < 7; i++) begin
      @(posedge core_clk_i);
      s = (i == 6) ? `OMLP_ADDR_WREG : 12'($urandom) & 12'hdff;
      a = (i == 1) ? `OMLP_ADDR_PCL : (i inside {[2:4]}) ?
          12'hffb + 12'(i) : (i == 5) ? `OMLP_ADDR_WREG :
          12'($urandom) & 12'hdff;
      r = $urandom;
      mem_rdata_i <= r;
      rv = (i == 6) ? acc : r;
      if (i != 6) expq.push_back({1'b0, s, 8'h00});
      if (i inside {[1:4]}) nbad++;
      else if (i == 5) acc = rv;
      else expq.push_back({1'b1, a, rv});
      st[9:2] = acc;
      issue({`OMLP_OP_FF1, s}, 1'b1);
      issue({`OMLP_OP_FF2, a}, 1'b0);
      fin;
      chk({accum_o, neg_flag_o, zero_flag_o}, st);
    end
    chk(bads, nbad);
    chk(expq.size(), 0);
    $display("file move test done");
    final_report;
  end
endmodule // tb
`default_nettype wire
